// File: mda_top.sv
// dma channel arbiter and transfer engine with avalon register slave
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module mda_top (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [31:0] singleReq,
	input  wire logic [31:0] burstReq,
	input  wire logic        cpuBusy,
	output logic             sysReq,
	output logic             sysWe,
	output logic [31:0]      sysAddr,
	output logic [31:0]      sysWdata,
	output logic [1:0]       sysSize,
	input  wire logic        sysAck,
	input  wire logic [31:0] sysRdata,
	output logic [31:0]      chanDone
);
	localparam int CW = 10;

	typedef struct packed {
		mda_pkg::mda_state_t st;
		logic [31:0] ena;
		logic [31:0] prio;
		logic [31:0] bonly;
		logic [31:0] mask;
		logic [31:0] swp;
		logic [31:0] alt;
		logic [21:0] base;
		logic [4:0]  ch;
		logic        isBurst;
		logic        ping;
		logic        fin;
		logic [31:0] srcEnd;
		logic [31:0] dstEnd;
		logic [31:0] cw;
		logic [31:0] data;
		logic [10:0] left;
		logic        sysReq;
		logic        sysWe;
		logic [31:0] sysAddr;
		logic [31:0] sysWdata;
		logic [1:0]  sysSize;
		logic [31:0] done;
		logic        waitreq;
		logic [31:0] rdata;
	} mda_eng_t;

	mda_eng_t r;
	mda_eng_t n;
	logic [31:0] elig;
	logic [31:0] wm;
	logic [31:0] wd;
	logic [7:0]  ofs;
	logic [31:0] tbl;
	logic [CW-1:0] cnt;
	logic        xfer;
	logic        acc;
	logic        gntValid;
	logic [4:0]  gntIdx;
	logic [10:0] arbN;
	logic [10:0] remN;

	// ****************************************************************
	// helpers
	// ****************************************************************

	// items per grant, encoded as a power of two up to 1024
	function automatic logic [10:0] arbItems(input logic [31:0] w);
		logic [3:0] lg;
		lg = w[mda_pkg::CW_ARB_LSB +: 4];
		if (lg > mda_pkg::ARB_LOG_MAX)
			lg = mda_pkg::ARB_LOG_MAX;
		arbItems = 11'h001 << lg;
	endfunction

	// end pointers are inclusive, so the item address counts back from the end
	function automatic logic [31:0] addrOf(input logic [31:0] endp, input logic [CW-1:0] c,
		input logic [1:0] inc);
		if (inc == mda_pkg::INC_NONE)
			addrOf = endp;
		else
			addrOf = endp - ({22'h0, c} << inc);
	endfunction

	// ****************************************************************
	// arbitration
	// ****************************************************************

	// channel roles are fixed by wiring; any channel may also be software driven
	assign elig = r.ena & ((~r.mask & (burstReq | (singleReq & ~r.bonly))) | r.swp);

	mda_arbiter #(
		.N (mda_pkg::NCH)
	) u_arb (
		.mclk     (mclk),
		.rstn     (rstn),
		.ce       (ce),
		.eligible (elig),
		.highPrio (r.prio),
		.gntValid (gntValid),
		.gntIdx   (gntIdx)
	);

	// ****************************************************************
	// engine and register slave
	// ****************************************************************

	assign tbl = {r.base, r.alt[r.ch], r.ch, 4'h0};
	assign cnt = r.cw[mda_pkg::CW_CNT_LSB +: CW];
	assign xfer = r.sysReq & sysAck;
	assign wm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wd = avs_writedata & wm;
	assign ofs = {avs_address, 2'b00};
	assign acc = (avs_read | avs_write) & ~r.waitreq;
	assign arbN = arbItems(sysRdata);
	assign remN = {1'b0, sysRdata[mda_pkg::CW_CNT_LSB +: CW]} + 11'h001;

	// bus requests drop whenever the processor wants the bus, so it never waits
	always_comb
	begin
		n = r;
		n.sysReq = 1'b0;
		n.sysWe = 1'b0;
		n.done = '0;
		n.waitreq = mda_pkg::RST_WAITREQ;
		case (r.st)
			mda_pkg::ST_IDLE:
			begin
				if (|elig)
					n.st = mda_pkg::ST_ARB;
			end
			mda_pkg::ST_ARB:
			begin
				if (gntValid)
				begin
					n.ch = gntIdx;
					n.isBurst = burstReq[gntIdx] | r.swp[gntIdx];
					n.st = mda_pkg::ST_FSRC;
				end
				else
					n.st = mda_pkg::ST_IDLE;
			end
			mda_pkg::ST_FSRC, mda_pkg::ST_FDST:
			begin
				if (xfer)
				begin
					if (r.st == mda_pkg::ST_FSRC)
					begin
						n.srcEnd = sysRdata;
						n.st = mda_pkg::ST_FDST;
					end
					else
					begin
						n.dstEnd = sysRdata;
						n.st = mda_pkg::ST_FCTL;
					end
				end
				else if (!cpuBusy)
				begin
					n.sysReq = 1'b1;
					n.sysAddr = tbl | {28'h0, (r.st == mda_pkg::ST_FSRC) ?
						mda_pkg::TBL_SRC : mda_pkg::TBL_DST};
					n.sysSize = mda_pkg::RST_SIZE;
				end
			end
			mda_pkg::ST_FCTL:
			begin
				if (xfer)
				begin
					n.cw = sysRdata;
					n.ping = sysRdata[1:0] == mda_pkg::MODE_PING;
					n.fin = 1'b0;
					if (sysRdata[mda_pkg::CW_MODE_LSB +: 2] == mda_pkg::MODE_STOP)
					begin
						n.ena[r.ch] = 1'b0; // stop mode disables the channel
						n.st = mda_pkg::ST_IDLE;
					end
					else
					begin
						if (!r.isBurst)
							n.left = 11'h001;
						else
							n.left = (arbN < remN) ? arbN : remN;
						n.st = mda_pkg::ST_RD;
					end
				end
				else if (!cpuBusy)
				begin
					n.sysReq = 1'b1;
					n.sysAddr = tbl | {28'h0, mda_pkg::TBL_CTL};
					n.sysSize = mda_pkg::RST_SIZE;
				end
			end
			mda_pkg::ST_RD:
			begin
				if (xfer)
				begin
					n.data = sysRdata;
					n.st = mda_pkg::ST_WR;
				end
				else if (!cpuBusy)
				begin
					n.sysReq = 1'b1;
					n.sysAddr = addrOf(r.srcEnd, cnt, r.cw[mda_pkg::CW_SINC_LSB +: 2]);
					n.sysSize = r.cw[mda_pkg::CW_SSZ_LSB +: 2];
				end
			end
			mda_pkg::ST_WR:
			begin
				if (xfer)
				begin
					n.left = r.left - 11'h001;
					if (cnt == '0)
					begin
						n.fin = 1'b1;
						n.cw[mda_pkg::CW_MODE_LSB +: 2] = mda_pkg::MODE_STOP;
						n.st = mda_pkg::ST_WB;
					end
					else
					begin
						n.cw[mda_pkg::CW_CNT_LSB +: CW] = cnt - 10'h001;
						n.st = (r.left == 11'h001) ? mda_pkg::ST_WB : mda_pkg::ST_RD;
					end
				end
				else if (!cpuBusy)
				begin
					n.sysReq = 1'b1;
					n.sysWe = 1'b1;
					n.sysAddr = addrOf(r.dstEnd, cnt, r.cw[mda_pkg::CW_DINC_LSB +: 2]);
					n.sysWdata = r.data;
					n.sysSize = r.cw[mda_pkg::CW_DSZ_LSB +: 2];
				end
			end
			mda_pkg::ST_WB:
			begin
				if (xfer)
				begin
					if (r.fin)
					begin
						n.done[r.ch] = 1'b1;
						n.swp[r.ch] = 1'b0;
						if (r.ping)
							n.alt[r.ch] = ~r.alt[r.ch];
						else
							n.ena[r.ch] = 1'b0;
					end
					n.st = mda_pkg::ST_IDLE;
				end
				else if (!cpuBusy)
				begin
					n.sysReq = 1'b1;
					n.sysWe = 1'b1;
					n.sysAddr = tbl | {28'h0, mda_pkg::TBL_CTL};
					n.sysWdata = r.cw;
					n.sysSize = mda_pkg::RST_SIZE;
				end
			end
			default:
				n.st = mda_pkg::ST_IDLE;
		endcase

		// register reads are captured when waitrequest drops
		if ((avs_read | avs_write) && r.waitreq)
		begin
			n.waitreq = 1'b0;
			n.rdata = '0;
			if (avs_read)
			begin
				case (ofs)
					mda_pkg::OFS_ENA_SET:   n.rdata = r.ena;
					mda_pkg::OFS_PRIO_SET:  n.rdata = r.prio;
					mda_pkg::OFS_BONLY_SET: n.rdata = r.bonly;
					mda_pkg::OFS_MASK_SET:  n.rdata = r.mask;
					mda_pkg::OFS_SWREQ:     n.rdata = r.swp;
					mda_pkg::OFS_TBL_BASE:  n.rdata = {r.base, 10'h000};
					mda_pkg::OFS_ALT_SEL:   n.rdata = r.alt;
					mda_pkg::OFS_STATUS:
						n.rdata = {23'h0, r.st != mda_pkg::ST_IDLE, 3'h0, r.ch};
					default:                n.rdata = '0;
				endcase
			end
		end

		// software sets come last so they win over a hardware clear
		if (acc && avs_write)
		begin
			case (ofs)
				mda_pkg::OFS_ENA_SET:   n.ena = n.ena | wd;
				mda_pkg::OFS_ENA_CLR:   n.ena = n.ena & ~wd;
				mda_pkg::OFS_PRIO_SET:  n.prio = r.prio | wd;
				mda_pkg::OFS_PRIO_CLR:  n.prio = r.prio & ~wd;
				mda_pkg::OFS_BONLY_SET: n.bonly = r.bonly | wd;
				mda_pkg::OFS_BONLY_CLR: n.bonly = r.bonly & ~wd;
				mda_pkg::OFS_MASK_SET:  n.mask = r.mask | wd;
				mda_pkg::OFS_MASK_CLR:  n.mask = r.mask & ~wd;
				mda_pkg::OFS_SWREQ:     n.swp = n.swp | wd;
				mda_pkg::OFS_TBL_BASE:  n.base = (r.base & ~wm[31:10]) | wd[31:10];
				default:                n.ena = n.ena;
			endcase
		end
	end

	// all state freezes while the clock enable is low
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			r <= '0;
			r.waitreq <= mda_pkg::RST_WAITREQ;
			r.sysSize <= mda_pkg::RST_SIZE;
		end
		else if (ce)
			r <= n;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.waitreq;
	assign sysReq = r.sysReq;
	assign sysWe = r.sysWe;
	assign sysAddr = r.sysAddr;
	assign sysWdata = r.sysWdata;
	assign sysSize = r.sysSize;
	assign chanDone = r.done;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_cpuWins;
		ce && cpuBusy |=> !sysReq;
	endproperty
	a_cpuWins: assert property (p_cpuWins) else $error("dma drove bus under cpu");

	property p_noPreempt;
		ce && r.st == mda_pkg::ST_WR && xfer && r.left != 11'h001 && cnt != '0
			|=> r.st == mda_pkg::ST_RD && r.ch == $past(r.ch);
	endproperty
	a_noPreempt: assert property (p_noPreempt) else $error("burst was pre-empted");

	property p_single;
		r.st == mda_pkg::ST_RD && !r.isBurst |-> r.left == 11'h001;
	endproperty
	a_single: assert property (p_single) else $error("single moved more than one");

	property p_burstMin;
		r.st == mda_pkg::ST_RD |-> r.left <= arbItems(r.cw) && r.left <= {1'b0, cnt} + 11'h001;
	endproperty
	a_burstMin: assert property (p_burstMin) else $error("burst too long");

	property p_prioSet;
		ce && acc && avs_write && ofs == mda_pkg::OFS_PRIO_SET
			|=> r.prio == ($past(r.prio) | $past(wd));
	endproperty
	a_prioSet: assert property (p_prioSet) else $error("priority set wrong");

	property p_burstOnly;
		ce && r.st == mda_pkg::ST_ARB && gntValid |=> r.isBurst || !r.bonly[r.ch];
	endproperty
	a_burstOnly: assert property (p_burstOnly) else $error("single served on burst-only");

	property p_wbStop;
		r.st == mda_pkg::ST_WB && r.fin && sysReq |-> sysWdata[1:0] == mda_pkg::MODE_STOP
			&& sysWdata[mda_pkg::CW_CNT_LSB +: CW] == '0;
	endproperty
	a_wbStop: assert property (p_wbStop) else $error("final write-back not stopped");
endmodule

// File: mda_pkg.sv
// shared constants and types of the multi-channel dma arbiter
package mda_pkg;

	// ****************************************************************
	// channel count and fixed channel roles
	// ****************************************************************
	localparam int NCH = 32;
	localparam logic [4:0] CH_ASYNC_RX = 5'h08; // async_serial_port_zero receive
	localparam logic [4:0] CH_ASYNC_TX = 5'h09;
	localparam logic [4:0] CH_SYNC_RX  = 5'h0A; // sync_serial_receive_path
	localparam logic [4:0] CH_SYNC_TX  = 5'h0B; // sync_serial_transmit_path
	localparam logic [4:0] CH_SOFTWARE = 5'h1E;

	// ****************************************************************
	// register byte offsets on the avalon slave
	// ****************************************************************
	localparam logic [7:0] OFS_ENA_SET   = 8'h00;
	localparam logic [7:0] OFS_ENA_CLR   = 8'h04;
	localparam logic [7:0] OFS_PRIO_SET  = 8'h08;
	localparam logic [7:0] OFS_PRIO_CLR  = 8'h0C;
	localparam logic [7:0] OFS_BONLY_SET = 8'h10;
	localparam logic [7:0] OFS_BONLY_CLR = 8'h14;
	localparam logic [7:0] OFS_MASK_SET  = 8'h18;
	localparam logic [7:0] OFS_MASK_CLR  = 8'h1C;
	localparam logic [7:0] OFS_SWREQ     = 8'h20;
	localparam logic [7:0] OFS_TBL_BASE  = 8'h24;
	localparam logic [7:0] OFS_ALT_SEL   = 8'h28;
	localparam logic [7:0] OFS_STATUS    = 8'h2C;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic       RST_WAITREQ = 1'b1;
	localparam logic [1:0] RST_SIZE    = 2'h2;

	// ****************************************************************
	// control table and control word layout
	// ****************************************************************
	localparam logic [3:0] TBL_SRC = 4'h0;
	localparam logic [3:0] TBL_DST = 4'h4;
	localparam logic [3:0] TBL_CTL = 4'h8;
	localparam int CW_MODE_LSB = 0;
	localparam int CW_CNT_LSB  = 4;
	localparam int CW_ARB_LSB  = 14;
	localparam int CW_SSZ_LSB  = 24;
	localparam int CW_SINC_LSB = 26;
	localparam int CW_DSZ_LSB  = 28;
	localparam int CW_DINC_LSB = 30;
	localparam logic [3:0] ARB_LOG_MAX = 4'hA;
	localparam logic [1:0] MODE_STOP  = 2'h0;
	localparam logic [1:0] MODE_BASIC = 2'h1;
	localparam logic [1:0] MODE_AUTO  = 2'h2;
	localparam logic [1:0] MODE_PING  = 2'h3;
	localparam logic [1:0] INC_NONE   = 2'h3;

	// ****************************************************************
	// engine states
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_IDLE, ST_ARB, ST_FSRC, ST_FDST, ST_FCTL, ST_RD, ST_WR, ST_WB
	} mda_state_t;

endpackage

// File: mda_arbiter.sv
// registered two-level fixed-priority channel arbiter
`timescale 1ns/1ps

module mda_arbiter #(
	parameter int N = 32
) (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire logic                 ce,
	input  wire logic [N-1:0]         eligible,
	input  wire logic [N-1:0]         highPrio,
	output logic                      gntValid,
	output logic [$clog2(N)-1:0]      gntIdx
);
	typedef struct packed {
		logic                 valid;
		logic [$clog2(N)-1:0] idx;
		logic [N-1:0]         eligPast;
		logic [N-1:0]         prioPast;
	} mda_arb_t;

	mda_arb_t r;
	mda_arb_t n;
	logic [N-1:0] pool;

	// lowest set bit wins, so channel 0 ranks first
	function automatic logic [$clog2(N)-1:0] lowestIdx(input logic [N-1:0] v);
		lowestIdx = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (v[i])
				lowestIdx = i[$clog2(N)-1:0];
		end
	endfunction

	// high-priority requesters shadow all default ones
	always_comb
	begin
		n = r;
		pool = (|(eligible & highPrio)) ? (eligible & highPrio) : eligible;
		n.valid = |eligible;
		n.idx = lowestIdx(pool);
		n.eligPast = eligible;
		n.prioPast = highPrio;
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			r <= '0;
		else if (ce)
			r <= n;
	end

	assign gntValid = r.valid;
	assign gntIdx = r.idx;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_highFirst;
		gntValid && |(r.eligPast & r.prioPast) |-> r.prioPast[gntIdx] && r.eligPast[gntIdx];
	endproperty
	a_highFirst: assert property (p_highFirst) else $error("default channel beat high");

	// no requester at the winner's own level may sit below the winner
	property p_lowNumber;
		gntValid |-> (r.eligPast & ~(r.prioPast ^ {N{r.prioPast[gntIdx]}})
			& ((N'(1) << gntIdx) - N'(1))) == '0;
	endproperty
	a_lowNumber: assert property (p_lowNumber) else $error("lower channel skipped");
endmodule

// File: mda_sysmem.sv
// system bus memory model standing on the far side of the dma master port
`timescale 1ns/1ps

module mda_sysmem (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        sysReq,
	input  wire logic        sysWe,
	input  wire logic [31:0] sysAddr,
	input  wire logic [31:0] sysWdata,
	input  wire logic [3:0]  lat,
	output logic             sysAck,
	output logic [31:0]      sysRdata
);
	// word memory holding the channel control table and the data buffers
	logic [31:0] m [0:1023];
	logic [3:0]  waitCnt;

	// ack after lat waiting cycles; data is toggled garbage whenever not acked
	// byte lanes are not modelled, every write stores the whole word
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			sysAck   <= 1'b0;
			waitCnt  <= 4'h0;
			sysRdata <= 32'h0;
		end
		else if (sysReq && sysAck)
		begin
			if (sysWe)
				m[sysAddr[11:2]] <= sysWdata;
			sysAck   <= 1'b0;
			waitCnt  <= 4'h0;
			sysRdata <= ~sysRdata;
		end
		else if (sysReq && waitCnt >= lat)
		begin
			sysAck   <= 1'b1;
			sysRdata <= sysWe ? ~sysRdata : m[sysAddr[11:2]];
		end
		else
		begin
			sysAck   <= 1'b0; // a withdrawn request loses its ack
			waitCnt  <= sysReq ? waitCnt + 4'h1 : 4'h0;
			sysRdata <= ~sysRdata;
		end
	end
endmodule

// File: test_mda_top.sv
// self-checking bench of the dma channel arbiter
`timescale 1ns/1ps

module test_mda_top;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic [5:0]  avsAddress = 6'h00;
	logic        avsRead = 1'b0;
	logic        avsWrite = 1'b0;
	logic [31:0] avsWdata = 32'h0;
	logic [3:0]  avsBe = 4'hF;
	logic [31:0] avsRdata;
	logic        avsWait;
	logic [31:0] singleReq = 32'h0;
	logic [31:0] burstReq = 32'h0;
	logic        cpuBusy = 1'b0;
	logic        sysReq, sysWe, sysAck;
	logic [31:0] sysAddr, sysWdata, sysRdata, chanDone;
	logic [1:0]  sysSize;
	logic [3:0]  lat = 4'h1;
	logic        busyOn = 1'b0, busyQ = 1'b0, cwSeen = 1'b0;
	logic [31:0] cwAddr = 32'h0, cwVal = 32'h0;
	logic [1:0]  cyc = 2'h0;
	int          errors = 0, nCompared = 0;

	always #50 mclk = ~mclk;

	// ****************************************************************
	// design and partner
	// ****************************************************************
	mda_top dut (.mclk(mclk), .rstn(rstn), .ce(ce), .avs_address(avsAddress),
		.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
		.avs_byteenable(avsBe), .avs_readdata(avsRdata), .avs_waitrequest(avsWait),
		.singleReq(singleReq), .burstReq(burstReq), .cpuBusy(cpuBusy), .sysReq(sysReq),
		.sysWe(sysWe), .sysAddr(sysAddr), .sysWdata(sysWdata), .sysSize(sysSize),
		.sysAck(sysAck), .sysRdata(sysRdata), .chanDone(chanDone));
	mda_sysmem mem (.mclk(mclk), .rstn(rstn), .sysReq(sysReq), .sysWe(sysWe),
		.sysAddr(sysAddr), .sysWdata(sysWdata), .lat(lat), .sysAck(sysAck),
		.sysRdata(sysRdata));

	// ****************************************************************
	// monitors
	// ****************************************************************
	// processor busy pattern (one cycle in four), processor-wins watch,
	// and capture of the first control word write-back of the watched channel
	always @(posedge mclk)
	begin
		if (busyQ && sysReq === 1'b1)
			bad("bus request right after processor busy");
		busyQ   <= cpuBusy;
		cyc     <= cyc + 2'h1;
		cpuBusy <= busyOn && cyc == 2'h3;
		if (sysReq === 1'b1 && sysAck === 1'b1)
			chk({30'h0, sysSize}, 32'h2, "bus item size");
		if (sysReq && sysAck && sysWe && sysAddr === cwAddr && !cwSeen)
		begin
			cwSeen <= 1'b1;
			cwVal  <= sysWdata;
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic bad(input string s);
		errors++;
		$display("unexpected at %0t: %s", $time, s);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		nCompared++;
		if (got !== exp)
			bad($sformatf("%s got %h want %h", s, got, exp));
	endtask

	task automatic endSim;
		$display("compared %0d, mismatches %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one avalon access; an edge passes first so no strobe is driven twice at once
	task automatic bus(input logic [7:0] ofs, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		avsAddress <= ofs[7:2];
		avsWrite   <= w;
		avsRead    <= !w;
		avsWdata   <= d;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (avsWait !== 1'b0 && n < 50);
		q = avsRdata;
		avsRead  <= 1'b0;
		avsWrite <= 1'b0;
		if (n >= 50)
		begin
			bad("avalon timeout");
			endSim;
		end
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		logic [31:0] q;
		bus(ofs, 1'b1, d, q);
	endtask

	task automatic rd(input logic [7:0] ofs, input logic [31:0] exp, input string s);
		logic [31:0] q;
		bus(ofs, 1'b0, 32'h0, q);
		chk(q, exp, s);
	endtask

	// control word: word sizes, word increments, given mode, items, log2 arb size
	function automatic logic [31:0] cw(input logic [1:0] md, input int n, input int lg);
		cw = {8'hAA, 6'h0, 4'(lg), 10'(n - 1), 2'h0, md};
	endfunction

	task automatic setch(input int ch, input int src, input int dst, input logic [31:0] c);
		mem.m[256 + ch * 4] = 32'(src);
		mem.m[257 + ch * 4] = 32'(dst);
		mem.m[258 + ch * 4] = c;
		cwAddr = 32'h408 + 32'(ch) * 32'h10;
		cwSeen = 1'b0;
	endtask

	task automatic wdone(input int ch);
		int n;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (chanDone === 32'h0 && n < 3000);
		chk(chanDone, 32'h1 << ch, "completion channel");
		if (n >= 3000)
			endSim;
	endtask

	task automatic wcw;
		int n;
		n = 0;
		while (!cwSeen && n < 3000)
		begin
			@(posedge mclk);
			n++;
		end
		if (n >= 3000)
		begin
			bad("no control write-back");
			endSim;
		end
	endtask

	// 80 cycles in which the watched channel must stay untouched
	task automatic quiet(input string s);
		logic any;
		any = 1'b0;
		repeat (80)
		begin
			@(posedge mclk);
			any = any | (chanDone != 32'h0) | cwSeen;
		end
		chk({31'h0, any}, 32'h0, s);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic tRegs;
		rd(mda_pkg::OFS_PRIO_SET, 32'h0, "priority reset");
		wr(mda_pkg::OFS_PRIO_SET, 32'h8000_0101);
		wr(mda_pkg::OFS_PRIO_CLR, 32'h0000_0100);
		rd(mda_pkg::OFS_PRIO_SET, 32'h8000_0001, "priority set clear");
		avsBe <= 4'h1;
		wr(mda_pkg::OFS_PRIO_CLR, 32'hFFFF_FFFF);
		avsBe <= 4'hF;
		rd(mda_pkg::OFS_PRIO_SET, 32'h8000_0000, "lane masked clear");
		wr(mda_pkg::OFS_PRIO_CLR, 32'h8000_0000);
		wr(mda_pkg::OFS_BONLY_SET, 32'h0000_4000);
		rd(mda_pkg::OFS_BONLY_SET, 32'h0000_4000, "burst-only set");
		wr(mda_pkg::OFS_BONLY_CLR, 32'h0000_4000);
		rd(8'hFC, 32'h0, "unmapped read");
		rd(mda_pkg::OFS_STATUS, 32'h0, "status idle");
		wr(mda_pkg::OFS_TBL_BASE, 32'h0000_07FF);
		rd(mda_pkg::OFS_TBL_BASE, 32'h0000_0400, "table base");
		$display("test registers done");
	endtask

	// four channels at once: two high priority, then two default
	task automatic tPrio;
		int chs[4] = '{3, 5, 20, 25};
		int ord[4] = '{20, 25, 3, 5};
		lat <= 4'h2;
		foreach (chs[i])
			setch(chs[i], chs[i] * 4, 32'h300 + chs[i] * 4, cw(mda_pkg::MODE_BASIC, 1, 0));
		wr(mda_pkg::OFS_PRIO_SET, 32'h0210_0000);
		wr(mda_pkg::OFS_ENA_SET, 32'h0210_0028);
		singleReq <= 32'h0210_0028;
		foreach (ord[i])
			wdone(ord[i]);
		singleReq <= 32'h0;
		rd(mda_pkg::OFS_ENA_SET, 32'h0, "enable self clear");
		chk(mem.m[270] & 32'h3FFF, 32'h0, "count and mode written back");
		chk(mem.m[195], 32'hC0DE_0003, "single item moved");
		wr(mda_pkg::OFS_PRIO_CLR, 32'hFFFF_FFFF);
		$display("test priority done");
	endtask

	// higher request raised mid-burst must wait for the burst to end
	task automatic tBurst;
		int n;
		n = 0;
		setch(1, 32'h4, 32'h380, cw(mda_pkg::MODE_BASIC, 1, 0));
		setch(12, 32'h54, 32'h354, cw(mda_pkg::MODE_BASIC, 6, 2));
		wr(mda_pkg::OFS_ENA_SET, 32'h0000_1002);
		singleReq[12] <= 1'b1;
		burstReq[12] <= 1'b1;
		do
			@(posedge mclk);
		while (!(sysReq && sysAck && sysWe) && ++n < 500);
		if (n >= 500)
		begin
			bad("no data write in burst");
			endSim;
		end
		burstReq[1] <= 1'b1;
		wcw;
		chk({22'h0, cwVal[13:4]}, 32'h1, "first burst length");
		wdone(1);
		wdone(12);
		for (int k = 0; k < 6; k++)
			chk(mem.m[208 + k], 32'hC0DE_0010 + 32'(k), "burst data");
		burstReq <= 32'h0;
		singleReq <= 32'h0;
		$display("test burst done");
	endtask

	// burst-only blocks single requests; a single request moves one item
	task automatic tSingle;
		setch(14, 32'h8C, 32'h39C, cw(mda_pkg::MODE_BASIC, 4, 3));
		wr(mda_pkg::OFS_BONLY_SET, 32'h0000_4000);
		wr(mda_pkg::OFS_ENA_SET, 32'h0000_4000);
		singleReq[14] <= 1'b1;
		quiet("single on burst-only channel");
		wr(mda_pkg::OFS_BONLY_CLR, 32'h0000_4000);
		// with the clock enable low the now eligible channel must stay frozen
		ce <= 1'b0;
		quiet("activity while clock enable low");
		ce <= 1'b1;
		wcw;
		chk({22'h0, cwVal[13:4]}, 32'h2, "single request length");
		singleReq <= 32'h0;
		wr(mda_pkg::OFS_ENA_CLR, 32'h0000_4000);
		$display("test single done");
	endtask

	// masked and disabled requests ignored; software channel under processor load
	task automatic tMask;
		setch(7, 32'h1C, 32'h3A0, cw(mda_pkg::MODE_BASIC, 1, 0));
		wr(mda_pkg::OFS_MASK_SET, 32'h0000_0080);
		wr(mda_pkg::OFS_ENA_SET, 32'h0000_0080);
		singleReq[7] <= 1'b1;
		quiet("masked request served");
		wr(mda_pkg::OFS_ENA_CLR, 32'h0000_0080);
		wr(mda_pkg::OFS_MASK_CLR, 32'h0000_0080);
		quiet("disabled request served");
		singleReq <= 32'h0;
		setch(30, 32'hC8, 32'h3B0, cw(mda_pkg::MODE_AUTO, 3, 0) | 32'hC000_0000);
		lat <= 4'h0;
		busyOn <= 1'b1;
		wr(mda_pkg::OFS_ENA_SET, 32'h4000_0000);
		wr(mda_pkg::OFS_SWREQ, 32'h4000_0000);
		wdone(30);
		chk(mem.m[236], 32'hC0DE_0032, "fixed destination");
		busyOn <= 1'b0;
		// ping-pong completion keeps the channel enabled and flips its structure
		setch(29, 32'hC8, 32'h3B4, cw(mda_pkg::MODE_PING, 1, 0));
		wr(mda_pkg::OFS_ENA_SET, 32'h2000_0000);
		wr(mda_pkg::OFS_SWREQ, 32'h2000_0000);
		wdone(29);
		rd(mda_pkg::OFS_ALT_SEL, 32'h2000_0000, "alternate selected");
		rd(mda_pkg::OFS_ENA_SET, 32'h2000_0000, "ping keeps enable");
		wr(mda_pkg::OFS_ENA_CLR, 32'h2000_0000);
		$display("test mask and software done");
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		for (int i = 0; i < 1024; i++)
			mem.m[i] = 32'hC0DE_0000 + 32'(i);
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		tRegs;
		tPrio;
		tBurst;
		tSingle;
		tMask;
		endSim;
	end
endmodule
